// file: core/tmirq_defines.svh
// Register offsets, field positions and reset values of the interrupt and pad block
`ifndef TMIRQ_DEFINES_SVH
`define TMIRQ_DEFINES_SVH

`define TMIRQ_OFS_IEN_SET      8'h20
`define TMIRQ_OFS_IEN_CLR      8'h24
`define TMIRQ_OFS_IMASK        8'h28
`define TMIRQ_OFS_STAT_CLR     8'h2c
`define TMIRQ_OFS_PARAMS       8'h30
`define TMIRQ_OFS_VERSION      8'h34
`define TMIRQ_OFS_FAST_WAVE    8'h38
`define TMIRQ_OFS_PAD_NORM     8'h3c
`define TMIRQ_OFS_PAD_FAST     8'h40

// Status bit positions
`define TMIRQ_B_RECEIVE_READY          0
`define TMIRQ_B_TRANSMIT_READY          1
`define TMIRQ_B_COMMAND_SLOT_READY           2
`define TMIRQ_B_COMMAND_COMPLETE          3
`define TMIRQ_B_IDLE           4
`define TMIRQ_B_BUS_IDLE_FLAG        5
`define TMIRQ_B_ADDRESS_PHASE_NACK           8
`define TMIRQ_B_DATA_PHASE_NACK           9
`define TMIRQ_B_ARB            10
`define TMIRQ_B_SMBUS_TIMEOUT           12
`define TMIRQ_B_PEC            13
`define TMIRQ_B_STOPACC        14
`define TMIRQ_B_MCACK          17

// Implemented interrupt source bits and sticky clearable bits
`define TMIRQ_IRQ_BITS         32'h0002_773f
`define TMIRQ_STICKY_BITS      32'h0002_7708
`define TMIRQ_MASK_RESET       32'h0000_0000
`define TMIRQ_CFG_RESET        32'h0000_0000

// Identity values are arbitrary
`define TMIRQ_VERSION_NUM      12'h001
`define TMIRQ_VARIANT_NUM      4'h0

// Filter codes
`define TMIRQ_FILT_STD_FAST    2'h2
`define TMIRQ_FILT_FAST_PLUS   2'h3
`define TMIRQ_FILT_HIGH_SPEED  2'h1

`endif

// file: core/tmirq_pad_sel.sv
// Pad setting selection between normal and high-speed register contents
`timescale 1ns/100ps
`include "tmirq_defines.svh"
module tmirq_pad_sel
    import tmirq_pkg::*;
(
    input  wire logic        highSpeed,
    input  wire logic [31:0] padNorm,
    input  wire logic [31:0] padFast,
    output tmirq_pad_s       padSel,
    output logic             filterOk
);
    tmirq_pad_s normF;
    tmirq_pad_s fastF;

    always_comb
    begin
        normF.filter       = padNorm[29:28];
        normF.clkSlew      = padNorm[25:24];
        normF.clkPullup    = 2'h0;
        normF.clkPulldown  = padNorm[18:16];
        normF.dataSlew     = padNorm[9:8];
        normF.dataPulldown = padNorm[2:0];
        fastF.filter       = padFast[29:28];
        fastF.clkSlew      = padFast[25:24];
        fastF.clkPullup    = padFast[21:20];
        fastF.clkPulldown  = padFast[18:16];
        fastF.dataSlew     = padFast[9:8];
        fastF.dataPulldown = padFast[2:0];
    end

    // Fast settings only during high-speed transfers
    assign padSel = highSpeed ? fastF : normF;

    // Reserved filter codes flagged
    assign filterOk = highSpeed ? (fastF.filter == `TMIRQ_FILT_HIGH_SPEED)
                                : (normF.filter[1] == 1'b1);
endmodule

// file: core/tmirq_pkg.sv
// Types shared by the interrupt and pad block
package tmirq_pkg;
    typedef struct packed {
        logic       wrEn;
        logic       rdEn;
        logic [7:0] addr;
        logic [31:0] wdata;
    } tmirq_bus_req_s;

    typedef struct packed {
        logic [1:0] filter;
        logic [1:0] clkSlew;
        logic [1:0] clkPullup;
        logic [2:0] clkPulldown;
        logic [1:0] dataSlew;
        logic [2:0] dataPulldown;
    } tmirq_pad_s;

    typedef struct packed {
        logic [2:0] prescExp;
        logic [3:0] dataHold;
        logic [7:0] startStop;
        logic [7:0] highTime;
        logic [7:0] lowTime;
    } tmirq_wave_s;
endpackage

// file: core/tmirq_regs.sv
// Interrupt mask, status clear, identity, fast waveform and pad registers
`timescale 1ns/100ps
`include "tmirq_defines.svh"
//
// Function
// - A one written to the enable-set register sets that mask bit, a zero leaves it.
// - A one written to the disable register clears that mask bit, a zero leaves it.
// - The mask register is read-only, resets to zero, and a one enables its source.
// - A one written to status-clear clears that sticky flag and its pending request.
// - Receive-ready is high exactly while a received byte is waiting.
// - The parameter register bit zero reports high-speed support.
// - The version register returns a 12-bit version and a variant, with no effect.
// - The fast waveform register sets the clock timing only during high-speed transfers.
// - Normal pad filter value 2 selects standard/fast, 3 fast-plus, 0 and 1 reserved.
// - Normal pad slew and pull-down fields apply in standard, fast and fast-plus mode.
// - The fast pad register adds clock pull-up; filter 1 is high-speed; applies in HS only.
// - In high-speed mode data pull-down strength comes from the fast pad register.
module tmirq_regs
    import tmirq_pkg::*;
#(
    parameter logic HS_SUPPORTED = 1'b1
)
(
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  tmirq_bus_req_s   busReq,
    output logic [31:0]      rdData_ff,
    output logic             rdValid_ff,
    input  wire logic        highSpeed,
    input  wire logic        rxByteWaiting,
    input  wire logic        txReady,
    input  wire logic        cmdSlotReady,
    input  wire logic        idle,
    input  wire logic        bus_idle_flag,
    input  wire logic [31:0] eventPulse,
    output logic             irq_ff,
    output tmirq_wave_s      clkWave_ff,
    output tmirq_pad_s       pad_ff,
    output logic             filterOk_ff
);
    logic [31:0] mask_ff;
    logic [31:0] sticky_ff;
    logic [31:0] fastWave_ff;
    logic [31:0] normWave_ff;
    logic [31:0] padNorm_ff;
    logic [31:0] padFast_ff;
    logic [31:0] status;
    logic [31:0] nxt_rdData;
    tmirq_pad_s  padSel;
    logic        filterOk;

    function automatic logic hit(input tmirq_bus_req_s r, input logic [7:0] ofs);
        hit = r.wrEn && (r.addr == ofs);
    endfunction

    // Mask register; enable-set wins over disable in the same cycle
    always_ff @(posedge core_clk)
    begin
        if (rst)
            mask_ff <= `TMIRQ_MASK_RESET;
        else if (hit(busReq, `TMIRQ_OFS_IEN_SET))
            mask_ff <= mask_ff | (busReq.wdata & `TMIRQ_IRQ_BITS);
        else if (hit(busReq, `TMIRQ_OFS_IEN_CLR))
            mask_ff <= mask_ff & ~busReq.wdata;
    end

    // Sticky flags; a new event wins over a clear in the same cycle
    always_ff @(posedge core_clk)
    begin
        if (rst)
            sticky_ff <= 32'h0000_0000;
        else if (hit(busReq, `TMIRQ_OFS_STAT_CLR))
            sticky_ff <= ((sticky_ff & ~busReq.wdata) | eventPulse)
                         & `TMIRQ_STICKY_BITS;
        else
            sticky_ff <= (sticky_ff | eventPulse) & `TMIRQ_STICKY_BITS;
    end

    // Live level flags follow their sources, no clear needed
    always_comb
    begin
        status = sticky_ff;
        status[`TMIRQ_B_RECEIVE_READY]   = rxByteWaiting;
        status[`TMIRQ_B_TRANSMIT_READY]   = txReady;
        status[`TMIRQ_B_COMMAND_SLOT_READY]    = cmdSlotReady;
        status[`TMIRQ_B_IDLE]    = idle;
        status[`TMIRQ_B_BUS_IDLE_FLAG] = bus_idle_flag;
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
            irq_ff <= 1'b0;
        else
            irq_ff <= |(status & mask_ff);
    end

    // Configuration registers
    always_ff @(posedge core_clk)
    begin
        if (rst)
            fastWave_ff <= `TMIRQ_CFG_RESET;
        else if (hit(busReq, `TMIRQ_OFS_FAST_WAVE))
            fastWave_ff <= busReq.wdata & 32'h7fff_ffff;
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
            padNorm_ff <= `TMIRQ_CFG_RESET;
        else if (hit(busReq, `TMIRQ_OFS_PAD_NORM))
            padNorm_ff <= busReq.wdata & 32'h3307_0307;
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
            padFast_ff <= `TMIRQ_CFG_RESET;
        else if (hit(busReq, `TMIRQ_OFS_PAD_FAST))
            padFast_ff <= busReq.wdata & 32'h3337_0307;
    end

    // Normal waveform lives elsewhere; held at reset value here
    always_ff @(posedge core_clk)
    begin
        normWave_ff <= `TMIRQ_CFG_RESET;
    end

    // Waveform used by the clock generator
    always_ff @(posedge core_clk)
    begin
        if (rst)
            clkWave_ff <= '0;
        else if (highSpeed)
            clkWave_ff <= fastWave_ff[30:0];
        else
            clkWave_ff <= normWave_ff[30:0];
    end

    tmirq_pad_sel u_pad_sel
    (
        .highSpeed (highSpeed),
        .padNorm   (padNorm_ff),
        .padFast   (padFast_ff),
        .padSel    (padSel),
        .filterOk  (filterOk)
    );

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            pad_ff      <= '0;
            filterOk_ff <= 1'b0;
        end
        else
        begin
            pad_ff      <= padSel;
            filterOk_ff <= filterOk;
        end
    end

    // Read mux; write-only and unmapped offsets read zero
    always_comb
    begin
        nxt_rdData = 32'h0000_0000;
        case (busReq.addr)
            `TMIRQ_OFS_IMASK:     nxt_rdData = mask_ff;
            `TMIRQ_OFS_PARAMS:    nxt_rdData = {31'h0, HS_SUPPORTED};
            `TMIRQ_OFS_VERSION:   nxt_rdData = {12'h000, `TMIRQ_VARIANT_NUM,
                                                4'h0, `TMIRQ_VERSION_NUM};
            `TMIRQ_OFS_FAST_WAVE: nxt_rdData = fastWave_ff;
            `TMIRQ_OFS_PAD_NORM:  nxt_rdData = padNorm_ff;
            `TMIRQ_OFS_PAD_FAST:  nxt_rdData = padFast_ff;
            default:              nxt_rdData = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            rdData_ff  <= 32'h0000_0000;
            rdValid_ff <= 1'b0;
        end
        else
        begin
            rdData_ff  <= busReq.rdEn ? nxt_rdData : 32'h0000_0000;
            rdValid_ff <= busReq.rdEn;
        end
    end
endmodule

// file: tb/tmirq_engine_model.sv
// Transfer engine stand-in: status levels and event pulses
`timescale 1ns/100ps
module tmirq_engine_model
(
    input  wire logic   core_clk,
    output logic        highSpeed,
    output logic [4:0]  lvl,
    output logic [31:0] eventPulse
);
    initial
    begin
        highSpeed = 1'b0;
        lvl = 5'h00;
        eventPulse = 32'h0000_0000;
    end
    // One cycle only, launched off the sampling edge
    task automatic fire(input logic [31:0] ev);
        @(negedge core_clk);
        eventPulse = ev;
        @(negedge core_clk);
        eventPulse = 32'h0000_0000;
    endtask
endmodule

// file: tb/tmirq_regs_bench.sv
// Self-checking bench of the register block
`timescale 1ns/100ps
`include "tmirq_defines.svh"
module tmirq_regs_bench
    import tmirq_pkg::*;
;
    logic           core_clk;
    logic           rst;
    tmirq_bus_req_s busReq;
    logic [31:0]    rdData_ff;
    logic           rdValid_ff;
    logic           highSpeed;
    logic [4:0]     lvl;
    logic [31:0]    eventPulse;
    logic           irq_ff;
    tmirq_wave_s    clkWave_ff;
    tmirq_pad_s     pad_ff;
    logic           filterOk_ff;
    logic [31:0]    oneHot;
    int             fail_count;
    int             compares;
    tmirq_regs u_tmirq_regs (.core_clk(core_clk), .rst(rst), .busReq(busReq),
        .rdData_ff(rdData_ff), .rdValid_ff(rdValid_ff), .highSpeed(highSpeed),
        .rxByteWaiting(lvl[0]), .txReady(lvl[1]), .cmdSlotReady(lvl[2]), .idle(lvl[3]),
        .bus_idle_flag(lvl[4]), .eventPulse(eventPulse), .irq_ff(irq_ff),
        .clkWave_ff(clkWave_ff), .pad_ff(pad_ff), .filterOk_ff(filterOk_ff));
    tmirq_engine_model u_tmirq_engine_model (.core_clk(core_clk), .highSpeed(highSpeed),
        .lvl(lvl), .eventPulse(eventPulse));
    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tick();
        @(negedge core_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        tick();
        busReq = '{1'b1, 1'b0, a, d};
        tick();
        busReq = '0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        tick();
        busReq = '{1'b0, 1'b1, a, 32'h0000_0000};
        tick();
        busReq = '0;
        chk(rdValid_ff, 32'h0000_0001);
        chk(rdData_ff, exp);
    endtask
    task automatic summarize();
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        #100000;
        fail_count++;
        summarize();
    end
    initial
    begin
        busReq = '0;
        rst = 1'b1;
        fail_count = 0;
        compares = 0;
        repeat (2) tick();
        rst = 1'b0;
        rd(8'h28, 32'h0000_0000);
        rd(8'h30, 32'h0000_0001);
        rd(8'h34, 32'h0000_0001);
        rd(8'h7c, 32'h0000_0000);
        wr(8'h20, 32'hffff_ffff);
        wr(8'h28, 32'h0000_0000);
        rd(8'h28, `TMIRQ_IRQ_BITS);
        wr(8'h24, 32'h0000_0009);
        wr(8'h20, 32'h0000_0000);
        rd(8'h28, 32'h0002_7736);
        wr(8'h24, 32'hffff_ffff);
        $display("mask test done");
        for (int i = 0; i < 18; i++)
        begin
            oneHot = 32'h0000_0001 << i;
            if ((oneHot & `TMIRQ_STICKY_BITS) != 0)
            begin
                u_tmirq_engine_model.fire(oneHot);
                tick();
                chk(irq_ff, 32'h0000_0000);
                wr(8'h20, oneHot);
                tick();
                chk(irq_ff, 32'h0000_0001);
                wr(8'h2c, oneHot);
                tick();
                chk(irq_ff, 32'h0000_0000);
                wr(8'h24, oneHot);
            end
        end
        wr(8'h20, 32'h0000_0001);
        u_tmirq_engine_model.lvl = 5'h01;
        repeat (2) tick();
        chk(irq_ff, 32'h0000_0001);
        u_tmirq_engine_model.lvl = 5'h00;
        repeat (2) tick();
        chk(irq_ff, 32'h0000_0000);
        $display("flag test done");
        wr(8'h3c, 32'hffff_ffff);
        wr(8'h40, 32'hffff_ffff);
        wr(8'h38, 32'hffff_ffff);
        rd(8'h3c, 32'h3307_0307);
        rd(8'h40, 32'h3337_0307);
        chk(pad_ff, 32'h0000_3cff);
        chk(clkWave_ff, 32'h0000_0000);
        u_tmirq_engine_model.highSpeed = 1'b1;
        repeat (2) tick();
        chk(pad_ff, 32'h0000_3fff);
        chk(clkWave_ff, 32'h7fff_ffff);
        chk(filterOk_ff, 32'h0000_0000);
        wr(8'h40, 32'h1000_0000);
        tick();
        chk(pad_ff, 32'h0000_1000);
        u_tmirq_engine_model.highSpeed = 1'b0;
        wr(8'h3c, 32'h2000_0000);
        tick();
        chk(filterOk_ff, 32'h0000_0001);
        wr(8'h3c, 32'h1000_0000);
        tick();
        chk(filterOk_ff, 32'h0000_0000);
        $display("pad test done");
        summarize();
    end
endmodule

// file: tb/tmirq_regs_properties.sv
// Port checks of the register block
`timescale 1ns/100ps
`include "tmirq_defines.svh"
module tmirq_regs_properties
    import tmirq_pkg::*;
#(
    parameter logic HS_SUPPORTED = 1'b1
)
(
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  tmirq_bus_req_s   busReq,
    input  wire logic [31:0] rdData_ff,
    input  wire logic        rdValid_ff,
    input  wire logic        highSpeed,
    input  wire logic        irq_ff,
    input  tmirq_wave_s      clkWave_ff,
    input  tmirq_pad_s       pad_ff,
    input  wire logic        filterOk_ff
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (rst);
    a_read_lag: assert property (busReq.rdEn |=> rdValid_ff)
        else $error("read not answered");
    a_param_bit: assert property (busReq.rdEn && busReq.addr == 8'h30
        |=> rdData_ff == {31'h0000_0000, HS_SUPPORTED}) else $error("param word wrong");
    a_version_word: assert property (busReq.rdEn && busReq.addr == 8'h34
        |=> rdData_ff == 32'h0000_0001) else $error("version word wrong");
    a_wo_reads_zero: assert property (busReq.rdEn && busReq.addr inside {8'h20, 8'h2c}
        |=> rdData_ff == 32'h0000_0000) else $error("write-only read not zero");
    a_mask_off_quiet: assert property (busReq.wrEn && busReq.addr == 8'h24
        && busReq.wdata == 32'hffff_ffff |-> ##2 !irq_ff) else $error("irq with mask off");
    a_wave_gated: assert property (!highSpeed |=> clkWave_ff == '0)
        else $error("fast waveform outside fast mode");
    a_pullup_normal: assert property (!highSpeed |=> pad_ff.clkPullup == 2'h0)
        else $error("pull-up outside fast mode");
    a_filter_legal: assert property (filterOk_ff == ($past(highSpeed) ?
        pad_ff.filter == 2'h1 : pad_ff.filter[1])) else $error("filter flag wrong");
    c_irq: cover property (irq_ff);
    c_fast: cover property (highSpeed && filterOk_ff);
    c_read: cover property (rdValid_ff);
endmodule
bind tmirq_regs tmirq_regs_properties #(.HS_SUPPORTED(HS_SUPPORTED)) u_props (
    .core_clk(core_clk), .rst(rst), .busReq(busReq), .rdData_ff(rdData_ff),
    .rdValid_ff(rdValid_ff), .highSpeed(highSpeed), .irq_ff(irq_ff),
    .clkWave_ff(clkWave_ff), .pad_ff(pad_ff), .filterOk_ff(filterOk_ff));
